// ===== design/fprc_defines.svh
`ifndef FPRC_DEFINES_SVH
`define FPRC_DEFINES_SVH

// ------------------------------------------------------------
// Geometry
// ------------------------------------------------------------
`define FPRC_NPORT 4'h4
`define FPRC_CNT_W 32

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define FPRC_ADR_CTRL 8'h00
`define FPRC_ADR_PSEL 8'h04
`define FPRC_ADR_DEFPRI 8'h08
`define FPRC_ADR_REGEN 8'h0c
`define FPRC_ADR_QMAP 8'h10
`define FPRC_ADR_STAT 8'h14
`define FPRC_ADR_DEFALL 8'h18
`define FPRC_ADR_CNT_HI 2'h1

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define FPRC_CTRL_VIEW 0
`define FPRC_STAT_ERR 0
`define FPRC_REGEN_RST 24'hfac688
`define FPRC_QMAP_RST 16'hfa41
`define FPRC_DEFPRI_RST 3'h0
`define FPRC_PSEL_RST 4'h0

`endif

// ===== design/fprc_pkg.sv
package fprc_pkg;
  typedef logic [2:0] fprc_pri_t;
  typedef logic [1:0] fprc_q_t;
  typedef logic [7:0][2:0] fprc_rgtab_t;
  typedef logic [7:0][1:0] fprc_qtab_t;
  typedef enum {KIND_RX, KIND_TX, KIND_FLT, KIND_FWD} fprc_kind_e;
endpackage : fprc_pkg

// ===== design/fprc_ctr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fprc_ctr_if;
  logic ev;
  logic clr;
  logic cleared;
  logic [31:0] value;
  modport ctr (input ev, input clr, input cleared, output value);
  modport src (output ev, output clr, output cleared, input value);
endinterface : fprc_ctr_if
`default_nettype wire

// ===== design/fprc_ctr.sv
`timescale 1ns/1ps
`default_nettype none
`include "fprc_defines.svh"
module fprc_ctr
  import fprc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  fprc_ctr_if.ctr bus
);
  logic [`FPRC_CNT_W-1:0] total_q;
  logic [`FPRC_CNT_W-1:0] snap_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      total_q <= '0;
    end else begin
      total_q <= total_q + {31'h0, bus.ev};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      snap_q <= '0;
    end else if (bus.clr) begin
      snap_q <= total_q;
    end
  end

  assign bus.value = bus.cleared ? total_q - snap_q : total_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // counts every event
  AST_CTR_INC: assert property (@(posedge clk_i) disable iff (rst_i)
    bus.ev |=> total_q == $past(total_q) + 32'h1)
    else $error("counter missed an event");
  AST_CTR_WRAP: assert property (@(posedge clk_i) disable iff (rst_i)
    (total_q == 32'hffffffff) && bus.ev |=> total_q == 32'h0)
    else $error("counter did not wrap");
  AST_CTR_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
    bus.clr && !bus.ev ##1 bus.cleared |-> bus.value == 32'h0)
    else $error("cleared view not zero");
  AST_CTR_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
    bus.clr && bus.ev |=> (total_q - snap_q) == 32'h1 && total_q == $past(total_q) + 32'h1)
    else $error("total lost by clear");
  COV_CTR_CLR_EV: cover property (@(posedge clk_i) disable iff (rst_i) bus.clr && bus.ev);
endmodule : fprc_ctr
`default_nettype wire

// ===== design/fprc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fprc_defines.svh"
module fprc_top
  import fprc_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic CL_VALID_I,
  input wire logic [1:0] CL_PORT_I,
  input wire logic CL_HAS_PRI_I,
  input wire logic [2:0] CL_PRI_I,
  input wire logic CL_OUT_TAGGED_I,
  output logic CL_VALID_O,
  output logic [2:0] CL_PRI_O,
  output logic [1:0] CL_QUEUE_O,
  output logic CL_WRITE_TAG_O,
  input wire logic [3:0] TXQ_PEND_I,
  output logic TXQ_VALID_O,
  output logic [1:0] TXQ_SEL_O,
  input wire logic [3:0] EV_RX_I,
  input wire logic [3:0] EV_TX_I,
  input wire logic [3:0] EV_FLT_I,
  input wire logic [3:0] EV_FWD_I
);
  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  logic ack_q;
  logic [31:0] dat_q;
  logic req;
  logic rd_ld;
  logic wr_en;
  logic [31:0] wmask;
  logic [31:0] rd_cur;
  logic [31:0] wv;
  logic hit_ctrl;
  logic hit_psel;
  logic hit_def;
  logic hit_regen;
  logic hit_qmap;
  logic hit_stat;
  logic hit_defall;
  logic hit_cnt;
  logic [3:0] cnt_idx;

  assign req = WB_CYC_I & WB_STB_I;
  assign rd_ld = req & ~ack_q;
  // The write lands on the edge where the master sees ack.
  assign wr_en = req & WB_WE_I & ack_q;
  assign wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  assign hit_ctrl = WB_ADR_I == `FPRC_ADR_CTRL;
  assign hit_psel = WB_ADR_I == `FPRC_ADR_PSEL;
  assign hit_def = WB_ADR_I == `FPRC_ADR_DEFPRI;
  assign hit_regen = WB_ADR_I == `FPRC_ADR_REGEN;
  assign hit_qmap = WB_ADR_I == `FPRC_ADR_QMAP;
  assign hit_stat = WB_ADR_I == `FPRC_ADR_STAT;
  assign hit_defall = WB_ADR_I == `FPRC_ADR_DEFALL;
  assign hit_cnt = (WB_ADR_I[7:6] == `FPRC_ADR_CNT_HI) && (WB_ADR_I[1:0] == 2'h0);
  assign cnt_idx = WB_ADR_I[5:2];

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= rd_ld;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      dat_q <= '0;
    end else if (rd_ld) begin
      dat_q <= rd_cur;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;

  // ------------------------------------------------------------
  // Control, port select and error state
  // ------------------------------------------------------------
  logic view_q;
  logic [3:0] psel_q;
  logic err_q;
  logic [1:0] sel_port;
  logic wr_ctrl;
  logic wr_psel;
  logic wr_stat;
  logic bad_port;
  logic clr_pulse;

  assign wr_ctrl = wr_en & hit_ctrl;
  assign wr_psel = wr_en & hit_psel;
  assign wr_stat = wr_en & hit_stat;
  assign bad_port = wr_psel & (wv[3:0] >= `FPRC_NPORT);
  assign clr_pulse = wr_ctrl & wv[`FPRC_CTRL_VIEW];
  assign sel_port = psel_q[1:0];

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      view_q <= 1'b0;
    end else if (wr_ctrl) begin
      view_q <= wv[`FPRC_CTRL_VIEW];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      psel_q <= `FPRC_PSEL_RST;
    end else if (wr_psel && !bad_port) begin
      psel_q <= wv[3:0];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      err_q <= 1'b0;
    end else begin
      err_q <= bad_port | (err_q & ~(wr_stat & wv[`FPRC_STAT_ERR]));
    end
  end

  // ------------------------------------------------------------
  // Per-port priority tables
  // ------------------------------------------------------------
  fprc_rgtab_t regen_q [4];
  fprc_qtab_t qmap_q [4];
  fprc_pri_t defpri_q [4];
  logic wr_def;
  logic wr_regen;
  logic wr_qmap;
  logic wr_defall;

  assign wr_def = wr_en & hit_def;
  assign wr_regen = wr_en & hit_regen;
  assign wr_qmap = wr_en & hit_qmap;
  assign wr_defall = wr_en & hit_defall;

  for (genvar g = 0; g < 4; g++) begin : g_port
    logic mine;
    assign mine = sel_port == 2'(g);

    always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
        regen_q[g] <= `FPRC_REGEN_RST;
      end else if (wr_regen && mine) begin
        regen_q[g] <= wv[23:0];
      end
    end

    always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
        qmap_q[g] <= `FPRC_QMAP_RST;
      end else if (wr_qmap && mine) begin
        qmap_q[g] <= wv[15:0];
      end
    end

    always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
        defpri_q[g] <= `FPRC_DEFPRI_RST;
      end else if (wr_defall || (wr_def && mine)) begin
        defpri_q[g] <= wv[2:0];
      end
    end

    AST_REGEN_RST: assert property (@(posedge MCLK_I)
      $fell(RST_I) |-> regen_q[g] == `FPRC_REGEN_RST)
      else $error("regeneration table not identity after reset");
    AST_QMAP_RST: assert property (@(posedge MCLK_I)
      $fell(RST_I) |-> qmap_q[g] == `FPRC_QMAP_RST)
      else $error("queue map defaults wrong after reset");
    AST_DEFPRI_RST: assert property (@(posedge MCLK_I)
      $fell(RST_I) |-> defpri_q[g] == 3'h0)
      else $error("default priority not zero after reset");
  end

  // ------------------------------------------------------------
  // Read selection
  // ------------------------------------------------------------
  logic [31:0] cnt_val [16];

  assign rd_cur = hit_ctrl ? {31'h0, view_q} :
                  hit_psel ? {28'h0, psel_q} :
                  hit_def ? {29'h0, defpri_q[sel_port]} :
                  hit_regen ? {8'h0, regen_q[sel_port]} :
                  hit_qmap ? {16'h0, qmap_q[sel_port]} :
                  hit_stat ? {31'h0, err_q} :
                  hit_cnt ? cnt_val[cnt_idx] :
                  32'h0;
  // Byte lanes not enabled take the register's present read value; DEFALL reads as zero, so its disabled lanes write zero.
  assign wv = (rd_cur & ~wmask) | (WB_DAT_I & wmask);

  // ------------------------------------------------------------
  // Classification stage
  // ------------------------------------------------------------
  fprc_pri_t pri_in;
  fprc_pri_t pri_rg;
  fprc_q_t queue_sel;
  fprc_pri_t def_pri_rg;
  logic cl_valid_q;
  fprc_pri_t cl_pri_q;
  fprc_q_t cl_queue_q;
  logic cl_tag_q;

  assign pri_in = CL_HAS_PRI_I ? CL_PRI_I : defpri_q[CL_PORT_I];
  assign pri_rg = regen_q[CL_PORT_I][pri_in];
  assign queue_sel = qmap_q[CL_PORT_I][pri_rg];
  assign def_pri_rg = regen_q[CL_PORT_I][defpri_q[CL_PORT_I]];

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      cl_valid_q <= 1'b0;
      cl_pri_q <= '0;
      cl_queue_q <= '0;
      cl_tag_q <= 1'b0;
    end else begin
      cl_valid_q <= CL_VALID_I;
      if (CL_VALID_I) begin
        cl_pri_q <= pri_rg;
        cl_queue_q <= queue_sel;
        cl_tag_q <= CL_OUT_TAGGED_I;
      end
    end
  end

  assign CL_VALID_O = cl_valid_q;
  assign CL_PRI_O = cl_pri_q;
  assign CL_QUEUE_O = cl_queue_q;
  assign CL_WRITE_TAG_O = cl_tag_q;

  // ------------------------------------------------------------
  // Transmit queue selection
  // ------------------------------------------------------------
  logic txq_valid_q;
  fprc_q_t txq_sel_q;
  fprc_q_t txq_pick;

  assign txq_pick = TXQ_PEND_I[3] ? 2'h3 :
                    TXQ_PEND_I[2] ? 2'h2 :
                    TXQ_PEND_I[1] ? 2'h1 : 2'h0;

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      txq_valid_q <= 1'b0;
      txq_sel_q <= '0;
    end else begin
      txq_valid_q <= |TXQ_PEND_I;
      txq_sel_q <= txq_pick;
    end
  end

  assign TXQ_VALID_O = txq_valid_q;
  assign TXQ_SEL_O = txq_sel_q;

  // ------------------------------------------------------------
  // Frame counters
  // ------------------------------------------------------------
  logic [3:0][3:0] ev_all;

  assign ev_all[KIND_RX] = EV_RX_I;
  assign ev_all[KIND_TX] = EV_TX_I;
  assign ev_all[KIND_FLT] = EV_FLT_I;
  assign ev_all[KIND_FWD] = EV_FWD_I;

  for (genvar k = 0; k < 4; k++) begin : g_kind
    for (genvar p = 0; p < 4; p++) begin : g_cnt
      fprc_ctr_if cif ();
      assign cif.ev = ev_all[k][p];
      assign cif.clr = clr_pulse;
      assign cif.cleared = view_q;
      assign cnt_val[k * 4 + p] = cif.value;
      fprc_ctr u_ctr (
        .clk_i (MCLK_I),
        .rst_i (RST_I),
        .bus (cif.ctr)
      );
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // queue from regenerated
  AST_CL_QUEUE: assert property (@(posedge MCLK_I) disable iff (RST_I)
    CL_VALID_I && !wr_en |=> CL_QUEUE_O == qmap_q[$past(CL_PORT_I)][CL_PRI_O])
    else $error("queue not taken from regenerated priority");
  AST_CL_DEFAULT: assert property (@(posedge MCLK_I) disable iff (RST_I)
    CL_VALID_I && !CL_HAS_PRI_I |=> CL_VALID_O && CL_PRI_O == $past(def_pri_rg))
    else $error("untagged frame ignored port default");
  AST_CL_TAG: assert property (@(posedge MCLK_I) disable iff (RST_I)
    CL_VALID_I |=> CL_WRITE_TAG_O == $past(CL_OUT_TAGGED_I))
    else $error("tag rewrite flag wrong");
  AST_PSEL_BAD: assert property (@(posedge MCLK_I) disable iff (RST_I)
    bad_port |=> err_q && $stable(psel_q) ##1 (err_q || $past(wr_stat)))
    else $error("bad port not rejected");
  AST_TXQ_TOP: assert property (@(posedge MCLK_I) disable iff (RST_I)
    TXQ_PEND_I[3] |=> TXQ_VALID_O && TXQ_SEL_O == 2'h3)
    else $error("highest queue not selected");
  AST_BUS_ACK: assert property (@(posedge MCLK_I) disable iff (RST_I)
    rd_ld |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("bus ack not one cycle");
  COV_BAD_PORT: cover property (@(posedge MCLK_I) disable iff (RST_I) bad_port);
  COV_CLEAR: cover property (@(posedge MCLK_I) disable iff (RST_I) clr_pulse ##[1:400] wr_ctrl && !wv[0]);
  COV_UNTAGGED: cover property (@(posedge MCLK_I) disable iff (RST_I) CL_VALID_I && !CL_HAS_PRI_I);
endmodule : fprc_top
`default_nettype wire

// ===== bench/fprc_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module fprc_far_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  output logic [15:0] ev_o,
  output logic [3:0] pend_o,
  output logic [15:0][31:0] cnt_o
);
  // ------------------------------------------------------------
  // Frame events and queue backlog
  // ------------------------------------------------------------
  // Events stop while disabled so that counts can be frozen before they are read.
  always @(posedge clk_i) begin
    for (int i = 0; i < 16; i++) begin
      if (rst_i) cnt_o[i] <= 32'h0;
      else if (ev_o[i]) cnt_o[i] <= cnt_o[i] + 32'h1;
    end
    ev_o <= (en_i && !rst_i) ? 16'($urandom) : 16'h0;
    pend_o <= rst_i ? 4'h0 : 4'($urandom);
  end
endmodule : fprc_far_model
`default_nettype wire

// ===== bench/frame_priority_regen_and_counters_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module frame_priority_regen_and_counters_tb_top;
  import fprc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, en = 1'b0, txon = 1'b0;
  logic [7:0] adr = 8'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic ack, clv = 1'b0, clh = 1'b0, clt = 1'b0, clvo, cltago, txv;
  logic [1:0] clp = 2'h0, clqo, txs;
  logic [2:0] clpri = 3'h0, clpo;
  logic [3:0] pend, pend_prev = 4'h0;
  logic [15:0] ev;
  logic [15:0][31:0] cnt, base;
  logic [23:0] rg [4];
  logic [15:0] qm [4];
  logic [2:0] dp [4];
  int num_errors = 0, num_checks = 0, tmo = 0;

  always #50 clk = ~clk;

  fprc_top i_dut (.MCLK_I(clk), .RST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .CL_VALID_I(clv), .CL_PORT_I(clp), .CL_HAS_PRI_I(clh), .CL_PRI_I(clpri),
    .CL_OUT_TAGGED_I(clt), .CL_VALID_O(clvo), .CL_PRI_O(clpo), .CL_QUEUE_O(clqo),
    .CL_WRITE_TAG_O(cltago), .TXQ_PEND_I(pend), .TXQ_VALID_O(txv), .TXQ_SEL_O(txs),
    .EV_RX_I(ev[3:0]), .EV_TX_I(ev[7:4]), .EV_FLT_I(ev[11:8]), .EV_FWD_I(ev[15:12]));

  fprc_far_model i_far (.clk_i(clk), .rst_i(rst), .en_i(en), .ev_o(ev), .pend_o(pend), .cnt_o(cnt));

  task close_out;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // The request waits for ack however long it takes; only the bench timeout ends a hang.
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0; stb <= 1'b0; wdat <= ~d;
  endtask : wb

  function automatic logic [1:0] hi(input logic [3:0] p);
    logic [1:0] h;
    h = 2'h0;
    for (int i = 0; i < 4; i++) if (p[i]) h = 2'(i);
    return h;
  endfunction : hi

  task check_port(input int p);
    logic [31:0] r;
    wb(1'b1, 8'h04, 32'(p), r);
    wb(1'b0, 8'h0c, 32'h0, r); chk("regen", {8'h0, rg[p]}, r);
    wb(1'b0, 8'h10, 32'h0, r); chk("qmap", {16'h0, qm[p]}, r);
    wb(1'b0, 8'h08, 32'h0, r); chk("defpri", {29'h0, dp[p]}, r[31:0] & 32'h7);
  endtask : check_port

  task frame(input int p, input logic h, input logic [2:0] pr, input logic t);
    logic [2:0] ip, e;
    ip = h ? pr : dp[p];
    e = rg[p][3*ip +: 3];
    @(posedge clk);
    clv <= 1'b1; clp <= 2'(p); clh <= h; clpri <= pr; clt <= t;
    @(posedge clk);
    clv <= 1'b0; clpri <= ~pr; clt <= ~t;
    @(posedge clk);
    chk("cl_valid", 32'h1, {31'h0, clvo});
    chk("cl_pri", {29'h0, e}, {29'h0, clpo});
    chk("cl_queue", {30'h0, qm[p][2*e +: 2]}, {30'h0, clqo});
    chk("cl_tag", {31'h0, t}, {31'h0, cltago});
  endtask : frame

  task read_cnt(input logic [15:0][31:0] off);
    logic [31:0] r;
    for (int i = 0; i < 16; i++) begin
      wb(1'b0, 8'(8'h40 + 4 * i), 32'h0, r);
      chk("counter", cnt[i] - off[i], r);
    end
  endtask : read_cnt

  // Strict-priority pick is judged against the backlog seen one edge earlier.
  always @(posedge clk) begin
    if (txon) begin
      chk("txq_valid", {31'h0, |pend_prev}, {31'h0, txv});
      chk("txq_sel", {30'h0, hi(pend_prev)}, {30'h0, txs});
    end
    pend_prev <= pend;
  end

  always @(posedge clk) begin
    tmo <= tmo + 1;
    if (tmo == 20000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    logic [31:0] r, v;
    int p;
    void'($urandom(32'hffdb));
    for (int i = 0; i < 4; i++) begin
      dp[i] = 3'h0;
      for (int j = 0; j < 8; j++) rg[i][3*j +: 3] = 3'(j);
      qm[i] = {2'h3, 2'h3, 2'h2, 2'h2, 2'h1, 2'h0, 2'h0, 2'h1};
    end
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    txon <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      check_port(i);
      for (int j = 0; j < 16; j++) frame(i, j[3], 3'(j), j[0]);
    end
    v = $urandom;
    wb(1'b1, 8'h18, v, r);
    for (int i = 0; i < 4; i++) dp[i] = v[2:0];
    for (int i = 0; i < 4; i++) begin
      check_port(i);
      rg[i] = 24'($urandom);
      qm[i] = 16'($urandom);
      wb(1'b1, 8'h0c, {8'h0, rg[i]}, r);
      wb(1'b1, 8'h10, {16'h0, qm[i]}, r);
      if (i != 1) begin
        dp[i] = 3'($urandom);
        wb(1'b1, 8'h08, {29'h0, dp[i]}, r);
      end
      check_port(i);
    end
    repeat (40) frame(int'($urandom % 4), 1'($urandom), 3'($urandom), 1'($urandom));
    p = 2;
    wb(1'b1, 8'h04, 32'(p), r);
    wb(1'b1, 8'h04, 32'(4 + $urandom % 12), r);
    wb(1'b0, 8'h04, 32'h0, r); chk("psel_kept", 32'(p), r & 32'hf);
    wb(1'b0, 8'h0c, 32'h0, r); chk("regen_kept", {8'h0, rg[p]}, r);
    wb(1'b0, 8'h14, 32'h0, r); chk("err_set", 32'h1, r & 32'h1);
    wb(1'b1, 8'h14, 32'h1, r);
    wb(1'b0, 8'h14, 32'h0, r); chk("err_clr", 32'h0, r & 32'h1);
    wb(1'b0, 8'h30, 32'h0, r); chk("unmapped", 32'h0, r);
    en <= 1'b1;
    repeat (200) @(posedge clk);
    en <= 1'b0;
    repeat (3) @(posedge clk);
    read_cnt('0);
    base = cnt;
    wb(1'b1, 8'h00, 32'h1, r);
    read_cnt(base);
    en <= 1'b1;
    repeat (100) @(posedge clk);
    en <= 1'b0;
    repeat (3) @(posedge clk);
    read_cnt(base);
    wb(1'b1, 8'h00, 32'h0, r);
    read_cnt('0);
    close_out();
  end
endmodule : frame_priority_regen_and_counters_tb_top
`default_nettype wire
